// ===== frs_host.sv
// Purpose: Host sequencer driving flash restart, select and output gate pins
// Assumes: Power-up begins at rst_n release; pins are active low
// Notes: Access is one select low window, gate low on reads only, held for hold_cyc + 1 cycles
`timescale 1ns/1ps
module frs_host (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // User side
  input  wire logic               restart_req,
  input  wire logic               access_req,
  input  wire logic               access_read,
  input  wire logic [7:0]         hold_cyc,
  output logic                    ready,
  output logic                    access_done,
  output logic                    busy,
  // Flash pins
  input  wire logic               done_pending_pin,
  output logic                    restart_pin_n,
  output logic                    select_pin_n,
  output logic                    gate_pin_n
);
  typedef struct packed {
    frs_pkg::frs_state_e          st;
    logic [frs_pkg::CNT_W-1:0]    cnt;
    logic [frs_pkg::CNT_W-1:0]    since_up;
    logic                         settled;
    logic                         rd;
    logic                         done;
    logic                         rdy;
    logic                         busy;
    frs_pkg::frs_pins_s           pins;
  } frs_host_s;

  frs_host_s st_r;
  frs_host_s st_nxt;
  logic      pend_sync;

  frs_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (done_pending_pin),
    .q     (pend_sync)
  );

  // Counter helpers shared by every timed state
  function automatic logic [frs_pkg::CNT_W-1:0] cyc(input int n);
    cyc = n[frs_pkg::CNT_W-1:0];
  endfunction

  function automatic logic [frs_pkg::CNT_W-1:0] cnt_inc(input logic [frs_pkg::CNT_W-1:0] c);
    cnt_inc = c + 1'b1;
  endfunction

  // Last cycle of a window of n cycles counted from zero
  function automatic logic cnt_hit(input logic [frs_pkg::CNT_W-1:0] c, input int n);
    cnt_hit = (c >= cyc(n - 1));
  endfunction

  // All control pins released high
  function automatic frs_pkg::frs_pins_s idle_pins();
    idle_pins.restart_n = 1'b1;
    idle_pins.select_n = 1'b1;
    idle_pins.gate_n = 1'b1;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;

    // Supply settle tracker; frozen once both supplies count as settled
    if (!st_r.settled) begin
      st_nxt.since_up = cnt_inc(st_r.since_up);
      if (cnt_hit(st_r.since_up, frs_pkg::SETTLE_CYC)) begin
        st_nxt.settled = 1'b1;
      end
    end

    case (st_r.st)
      // Controls are ignored by the device here; host keeps pins idle
      frs_pkg::FRS_POWER_UP: begin
        st_nxt.pins = idle_pins();
        if (restart_req) begin
          st_nxt.st = frs_pkg::FRS_PULSE;
          st_nxt.cnt = '0;
          st_nxt.pins.restart_n = 1'b0;
        end else if (st_r.settled && pend_sync) begin
          st_nxt.st = frs_pkg::FRS_SEL_HIGH;
          st_nxt.cnt = '0;
        end
      end

      frs_pkg::FRS_PULSE: begin
        st_nxt.cnt = cnt_inc(st_r.cnt);
        if (cnt_hit(st_r.cnt, frs_pkg::PULSE_CYC)) begin
          st_nxt.st = frs_pkg::FRS_RESTART_WAIT;
        end
      end

      // Counts restart-to-select, but only once both supplies settled
      frs_pkg::FRS_RESTART_WAIT: begin
        if (!st_r.settled) begin
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = cnt_inc(st_r.cnt);
        end
        // Release leaves margin; wait plus release spans full restart-to-select
        if (st_r.settled && cnt_hit(st_r.cnt, frs_pkg::RST_SEL_CYC - frs_pkg::RELEASE_CYC)) begin
          st_nxt.st = frs_pkg::FRS_RELEASE;
          st_nxt.cnt = '0;
          st_nxt.pins.restart_n = 1'b1;
        end
      end

      frs_pkg::FRS_RELEASE: begin
        st_nxt.cnt = cnt_inc(st_r.cnt);
        // Busy pin also gates exit: covers a full cold run on late restart
        if (cnt_hit(st_r.cnt, frs_pkg::RELEASE_CYC) && pend_sync) begin
          st_nxt.st = frs_pkg::FRS_READY;
        end
      end

      frs_pkg::FRS_READY: begin
        if (restart_req) begin
          st_nxt.st = frs_pkg::FRS_PULSE;
          st_nxt.cnt = '0;
          st_nxt.pins.restart_n = 1'b0;
        end else if (!pend_sync) begin
          // Device went busy on its own; never select into a busy part
          st_nxt.st = frs_pkg::FRS_RELEASE;
          st_nxt.cnt = '0;
        end else if (access_req) begin
          st_nxt.st = frs_pkg::FRS_ACCESS;
          st_nxt.cnt = '0;
          st_nxt.rd = access_read;
          st_nxt.pins.select_n = 1'b0;
          st_nxt.pins.gate_n = ~access_read;
        end
      end

      frs_pkg::FRS_ACCESS: begin
        st_nxt.cnt = cnt_inc(st_r.cnt);
        st_nxt.pins.gate_n = ~st_r.rd;
        if (st_r.cnt >= {{(frs_pkg::CNT_W-8){1'b0}}, hold_cyc}) begin
          st_nxt.st = frs_pkg::FRS_SEL_HIGH;
          st_nxt.cnt = '0;
          st_nxt.done = 1'b1;
          st_nxt.pins = idle_pins();
        end
      end

      frs_pkg::FRS_SEL_HIGH: begin
        st_nxt.cnt = cnt_inc(st_r.cnt);
        if (cnt_hit(st_r.cnt, frs_pkg::SEL_HIGH_CYC) && pend_sync) begin
          st_nxt.st = frs_pkg::FRS_READY;
        end
      end

      default: begin
        st_nxt.st = frs_pkg::FRS_POWER_UP;
      end
    endcase

    // Registered ready mirrors the next state; busy is the inverted synchronised done_pending_pin
    st_nxt.rdy = (st_nxt.st == frs_pkg::FRS_READY);
    st_nxt.busy = ~pend_sync;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.st <= frs_pkg::FRS_POWER_UP;
      st_r.cnt <= '0;
      st_r.since_up <= '0;
      st_r.settled <= 1'b0;
      st_r.rd <= 1'b0;
      st_r.done <= 1'b0;
      st_r.rdy <= 1'b0;
      st_r.busy <= 1'b0;
      st_r.pins <= 3'b111;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ready = st_r.rdy;
  assign access_done = st_r.done;
  assign busy = st_r.busy;
  assign restart_pin_n = st_r.pins.restart_n;
  assign select_pin_n = st_r.pins.select_n;
  assign gate_pin_n = st_r.pins.gate_n;
endmodule

// ===== frs_pkg.sv
// Purpose: Constants and types for the flash restart sequencing host controller
// Assumes: 250 MHz clock, host drives restart, select and output gate pins
// Notes: Rules carried by host logic, checker, bench and flash model
// Function
// - Host starts access by select falling edge
// - Optional power-up restart still meets timings
// - Pulse 200 ns, restart-to-select 35 us
// - Release restart 50 ns before select
// - Restart wait plus release covers restart-to-select
// - Select high at least 20 ns
// - Late release counts from settle end
package frs_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CORE_SETTLE_US = 300;
  localparam int IO_SETTLE_US = 300;
  localparam int RESTART_TO_SELECT_US = 35;
  localparam int PULSE_WIDTH_NS = 200;
  localparam int RELEASE_TO_SELECT_NS = 50;
  localparam int SELECT_HIGH_NS = 20;
  localparam int CORE_SETTLE_CYC = CORE_SETTLE_US * CLK_MHZ;
  localparam int IO_SETTLE_CYC = IO_SETTLE_US * CLK_MHZ;
  localparam int SETTLE_CYC = (CORE_SETTLE_CYC > IO_SETTLE_CYC) ? CORE_SETTLE_CYC : IO_SETTLE_CYC;
  localparam int RST_SEL_CYC = RESTART_TO_SELECT_US * CLK_MHZ;
  localparam int PULSE_CYC = (PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int RELEASE_CYC = (RELEASE_TO_SELECT_NS * CLK_MHZ + 999) / 1000;
  localparam int SEL_HIGH_CYC = (SELECT_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 20;

  typedef enum logic [2:0] {
    FRS_POWER_UP,
    FRS_PULSE,
    FRS_RESTART_WAIT,
    FRS_RELEASE,
    FRS_READY,
    FRS_ACCESS,
    FRS_SEL_HIGH
  } frs_state_e;

  typedef struct packed {
    logic restart_n;
    logic select_n;
    logic gate_n;
  } frs_pins_s;
endpackage

// ===== frs_sync.sv
// Purpose: Two-flop synchroniser for the busy pin
// Assumes: Input is asynchronous to clk
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module frs_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Data
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } frs_sync_s;
  frs_sync_s st_r;
  frs_sync_s st_nxt;
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= 2'b11;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule

// ===== frs_host_sva.sv
// Purpose: Pin timing checks on the restart host
// Assumes: One clock domain, async active-low reset
// Notes: Pulse and gap figures follow frs_pkg constants
`timescale 1ns/1ps
module frs_host_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input wire logic ready,
  input wire logic access_done,
  input wire logic busy,
  input wire logic done_pending_pin,
  input wire logic restart_pin_n,
  input wire logic select_pin_n,
  input wire logic gate_pin_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PULSE: assert property ($fell(restart_pin_n) |-> !restart_pin_n throughout (##49 1'b1)) else $error("short pulse");
  AST_NO_SEL: assert property (!restart_pin_n |-> select_pin_n) else $error("select in restart");
  AST_RELEASE: assert property ($fell(select_pin_n) |-> $past(restart_pin_n, 13)) else $error("release gap");
  AST_SEL_HIGH: assert property ($rose(select_pin_n) |-> select_pin_n [*5]) else $error("select high short");
  AST_DONE: assert property (access_done |-> $rose(select_pin_n)) else $error("done without end");
  AST_GATE: assert property (!gate_pin_n |-> !select_pin_n) else $error("gate outside access");
  AST_BUSY_SEL: assert property (!done_pending_pin |-> select_pin_n) else $error("access while busy");
  AST_READY: assert property (ready |-> restart_pin_n && select_pin_n && !busy) else $error("bad ready");
endmodule
bind frs_host frs_host_sva i_frs_host_sva (.clk(clk), .rst_n(rst_n), .ready(ready), .access_done(access_done),
  .busy(busy), .done_pending_pin(done_pending_pin), .restart_pin_n(restart_pin_n),
  .select_pin_n(select_pin_n), .gate_pin_n(gate_pin_n));

// ===== frs_flash_model.sv
// Purpose: Behavioural flash restart model
// Assumes: rst_n release is power-up
// Notes: Controls ignored until cold sequence ends
`timescale 1ns/1ps
module frs_flash_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pins
  input  wire logic restart_pin_n,
  output logic      done_pending_pin
);
  int unsigned cnt_r;
  logic        cold_done_r;
  logic        pin_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= frs_pkg::SETTLE_CYC;
      cold_done_r <= 1'b0;
      pin_d_r     <= 1'b1;
    end else begin
      pin_d_r <= restart_pin_n;
      if (cnt_r != 0) cnt_r <= cnt_r - 1;
      else if (!cold_done_r) cold_done_r <= 1'b1;
      else if (pin_d_r && !restart_pin_n) cnt_r <= frs_pkg::RST_SEL_CYC;
    end
  end
  assign done_pending_pin = (cnt_r == 0);
endmodule

// ===== tb_frs_host.sv
// Purpose: Self-checking bench for the restart host
// Assumes: Full 300 us settle, no shortening parameter
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_frs_host;
  logic       clk = 0, rst_n = 0, restart_req = 0, access_req = 0, access_read = 0;
  logic [7:0] hold_cyc = 8'h00;
  logic       ready, access_done, busy, dpp, rpin_n, spin_n, gpin_n;
  int         errors = 0, check_count = 0, n;
  frs_host i_frs_host (.clk(clk), .rst_n(rst_n), .restart_req(restart_req), .access_req(access_req),
    .access_read(access_read), .hold_cyc(hold_cyc), .ready(ready), .access_done(access_done), .busy(busy),
    .done_pending_pin(dpp), .restart_pin_n(rpin_n), .select_pin_n(spin_n), .gate_pin_n(gpin_n));
  frs_flash_model i_frs_flash_model (.clk(clk), .rst_n(rst_n), .restart_pin_n(rpin_n), .done_pending_pin(dpp));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_for(input int which, input int lim);
    n = 0;
    while (((which == 0) ? ready : access_done) !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic t_power_up();
    repeat (10) @(posedge clk);
    #1 chk(busy, 1);
    wait_for(0, 80000);
    chk(n >= frs_pkg::SETTLE_CYC - 10 && n < 80000, 1);
  endtask
  task automatic t_access(input logic rd, input logic [7:0] h);
    access_req = 1;
    access_read = rd;
    hold_cyc = h;
    @(posedge clk);
    #1 access_req = 0;
    chk(spin_n, 0);
    chk(gpin_n, !rd);
    wait_for(1, 300);
    chk(n, h + 1);
    wait_for(0, 300);
    chk(n, frs_pkg::SEL_HIGH_CYC);
  endtask
  task automatic t_warm();
    restart_req = 1;
    @(posedge clk);
    #1 restart_req = 0;
    chk({rpin_n, spin_n, ready}, 3'b010);
    repeat (100) @(posedge clk);
    #1 chk(busy, 1);
    wait_for(0, 9000);
    chk(n + 100 >= frs_pkg::RST_SEL_CYC && n < 9000, 1);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    t_power_up();
    t_access(1'b1, 8'h03);
    t_access(1'b0, 8'h00);
    t_warm();
    t_access(1'b1, 8'h07);
    wrap_up();
  end
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule
